// ---- verilog/capture_cfg.svh ----
// constants for the gated count capture block: sizes, limits, reset values
// assumes inclusion by the package, the design file and the testbench only
`ifndef CAPTURE_CFG_SVH
`define CAPTURE_CFG_SVH
`define CH_COUNT 8
`define CNT_W 32
`define TMR_W 40
`define ADDR_W 15
`define MEM_DEPTH 30000
`define ADDR_LAST 15'h752F
`define ADDR_SET_MAX 15'h270F
`define FIFO_DEPTH 32
`define CLK_PERIOD_NS 10
`define TIMER_UNIT_NS 1000
`define TIMER_TICK_CYC (`TIMER_UNIT_NS / `CLK_PERIOD_NS)
`define END_ADDR_RESET 15'h752F
`define FLAG_RUNOUT_BIT 6
`define FLAG_CNTON_BIT 5
`define FLAG_TMROVF_BIT 4
`define FLAG_CH7_BIT 3
`endif

// ---- verilog/capture_pkg.sv ----
// types shared by the gated count capture block
// assumes capture_cfg.svh is on the include path
`include "capture_cfg.svh"
package capture_pkg;
  typedef enum logic [4:0] {
    CMD_BAD = 5'h00, CMD_OVF_Q = 5'h01, CMD_OVFX_Q = 5'h02,
    CMD_ACK_EN = 5'h03, CMD_ACK_DS = 5'h04, CMD_ACK_Q = 5'h05,
    CMD_FLAG_Q = 5'h06, CMD_CLR_ADDR = 5'h07, CMD_CLR_ALL = 5'h08,
    CMD_SET_ADDR = 5'h09, CMD_ADDR_Q = 5'h0A, CMD_SET_END = 5'h0B,
    CMD_END_Q = 5'h0C, CMD_SEL_DIF = 5'h0D, CMD_SEL_FUL = 5'h0E,
    CMD_CAPT_Q = 5'h0F, CMD_GATE_START = 5'h10, CMD_EDGE_START = 5'h11,
    CMD_STOP = 5'h12
  } cmd_e;
  typedef enum logic [3:0] {
    REP_OK = 4'h0, REP_NG = 4'h1, REP_OVER = 4'h2, REP_EN = 4'h3,
    REP_DS = 4'h4, REP_HEX8 = 4'h5, REP_DEC = 4'h6, REP_FUL = 4'h7,
    REP_DIF = 4'h8
  } reply_e;
  typedef enum logic [1:0] {
    ACQ_IDLE = 2'b00, ACQ_LEVEL = 2'b01, ACQ_EDGE_WAIT = 2'b10,
    ACQ_EDGE_RUN = 2'b11
  } acq_e;
  typedef struct packed {
    cmd_e code;
    logic [31:0] arg;
  } cmd_s;
  typedef struct packed {
    reply_e kind;
    logic tm;
    logic [31:0] data;
  } reply_s;
  typedef struct packed {
    logic [`CH_COUNT-1:0][`CNT_W-1:0] cnt;
    logic [`TMR_W-1:0] timer;
  } rec_data_s;
  typedef struct packed {
    logic [`ADDR_W-1:0] addr;
    rec_data_s data;
  } record_s;
endpackage

// ---- verilog/gated_count_capture_to_memory.sv ----
// gated count capture: eight counters and a timer, snapshots to memory
// assumes decoded text commands arrive as cmd_s words, replies leave as
// reply_s words; count, gate, start and stop pins are asynchronous
`timescale 1ns/1ns
`include "capture_cfg.svh"

// three-stage pin synchroniser, a change counts once stages 2 and 3 agree
module pin_filter #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  // shift chain and agreement filter
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      level <= '0;
    end else if (ce) begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      level <= (s2_reg & s3_reg) | (level & (s2_reg | s3_reg));
    end
  end
endmodule

// snapshot fifo with valid and ready on both sides
module snap_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 32
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] fill_reg;
  logic push;
  logic pop;
  assign in_ready = (fill_reg != DEPTH[AW:0]);
  assign out_valid = (fill_reg != '0);
  assign out_data = mem[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // storage
  always_ff @(posedge clock) begin
    if (ce && push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end
  // pointers and fill level
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      fill_reg <= '0;
    end else if (ce) begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      fill_reg <= fill_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

// Contract
// - overflow inquiry answers a 2-hex-digit mask, bit n for counter n
// - overflow answer carries timer suffix only when timer overflowed
// - in ack-all mode silent commands other than ack-all disable answer OK, unparsable ones NG
// - ack-all enable turns the mode on at once and answers OK
// - after ack-all disable, silent commands give no answer
// - ack-all query answers EN when on, DS when off
// - flag byte queries answer the chosen byte as two hex digits
// - byte 0 holds overflow of counters 0-3, byte 1 of 4-6
// - byte 2: start, stop, gate levels, ch7 ovf, timer ovf, run, run-out
// - byte 3 low bits: gate, timer-gate, gate-edge mode active
// - gate-level mode counts while gate high, stores at gate fall; a fall in a cycle that takes a command is not stored
// - gate-edge mode starts at first fall, stores at every later fall; a fall in a cycle that takes a command neither starts nor stores
// - memory holds 30000 records, addresses 0 to 29999
// - acquisition stops by itself when current address reaches end
// - clear-address sets current address to zero, memory untouched
// - clear-all zeroes address and memory, commands wait until done
// - current address is settable 0 to 9999 and readable
// - end address is settable and readable in decimal
// - records hold accumulated or increment values, accumulated at reset
// - gate-level start stores from current to end; stop halts at once
// - gate-edge start likewise; stop halts at once
module gated_count_capture_to_memory (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire capture_pkg::cmd_s cmd,
  input wire logic cmd_valid,
  output logic cmd_ready,
  output capture_pkg::reply_s reply,
  output logic reply_valid,
  input wire logic [`CH_COUNT-1:0] count_pin,
  input wire logic gate_pin,
  input wire logic start_pin,
  input wire logic stop_pin,
  input wire logic [`ADDR_W-1:0] rd_addr,
  output capture_pkg::rec_data_s rd_data
);
  localparam logic [6:0] TICK_LAST = 7'(`TIMER_TICK_CYC - 1);
  logic [`CH_COUNT+2:0] pin_level;
  logic [`CH_COUNT+2:0] pin_prev_reg;
  logic [`CH_COUNT-1:0] cnt_rise;
  logic gate_fall;
  capture_pkg::acq_e acq_reg;
  logic [`CH_COUNT-1:0][`CNT_W-1:0] cnt_reg;
  logic [`CH_COUNT-1:0][`CNT_W-1:0] last_reg;
  logic [`CH_COUNT-1:0] ovf_reg;
  logic [`TMR_W-1:0] tmr_reg;
  logic [6:0] tick_reg;
  logic tmr_ovf_reg;
  logic count_en;
  logic runout_reg;
  logic ack_all_reg;
  logic dif_reg;
  logic [`ADDR_W-1:0] cur_addr_reg;
  logic [`ADDR_W-1:0] end_addr_reg;
  logic clearing_reg;
  logic [`ADDR_W-1:0] clr_ptr_reg;
  logic take;
  logic store;
  logic pend_reg;
  capture_pkg::record_s pend_rec_reg;
  logic fifo_in_ready;
  logic fifo_out_valid;
  capture_pkg::record_s fifo_out;
  capture_pkg::rec_data_s mem [`MEM_DEPTH];
  logic [7:0] flag_byte [4];
  logic [`CH_COUNT-1:0][`CNT_W-1:0] snap_val;

  // pins: counters, then gate, start, stop
  pin_filter #(.W(`CH_COUNT + 3)) u_pins (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .pin({stop_pin, start_pin, gate_pin, count_pin}),
    .level(pin_level)
  );

  // edges of filtered pin levels
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pin_prev_reg <= '0;
    end else if (ce) begin
      pin_prev_reg <= pin_level;
    end
  end
  assign cnt_rise = pin_level[`CH_COUNT-1:0] & ~pin_prev_reg[`CH_COUNT-1:0];
  assign gate_fall = !pin_level[`CH_COUNT] && pin_prev_reg[`CH_COUNT];

  // counting window per mode
  assign count_en = (acq_reg == capture_pkg::ACQ_EDGE_RUN) ||
    ((acq_reg == capture_pkg::ACQ_LEVEL) && pin_level[`CH_COUNT]);
  assign take = cmd_valid && cmd_ready;
  assign store = gate_fall && ((acq_reg == capture_pkg::ACQ_LEVEL) ||
    (acq_reg == capture_pkg::ACQ_EDGE_RUN)) && !take;

  // channel counters and sticky overflow flags
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      ovf_reg <= '0;
    end else if (ce) begin
      for (int i = 0; i < `CH_COUNT; i++) begin
        if (count_en && cnt_rise[i]) begin
          cnt_reg[i] <= cnt_reg[i] + 1'b1;
          if (&cnt_reg[i]) begin
            ovf_reg[i] <= 1'b1;
          end
        end
      end
    end
  end

  // microsecond timer running with the counters
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tmr_reg <= '0;
      tick_reg <= '0;
      tmr_ovf_reg <= 1'b0;
    end else if (ce && count_en) begin
      tick_reg <= (tick_reg == TICK_LAST) ? '0 : tick_reg + 1'b1;
      if (tick_reg == TICK_LAST) begin
        tmr_reg <= tmr_reg + 1'b1;
        if (&tmr_reg) begin
          tmr_ovf_reg <= 1'b1;
        end
      end
    end
  end

  // snapshot values: accumulated or increment since last store
  always_comb begin
    for (int i = 0; i < `CH_COUNT; i++) begin
      snap_val[i] = dif_reg ? cnt_reg[i] - last_reg[i] : cnt_reg[i];
    end
  end

  // acquisition state and current address
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      acq_reg <= capture_pkg::ACQ_IDLE;
      cur_addr_reg <= '0;
      runout_reg <= 1'b0;
    end else if (ce) begin
      if (take) begin
        case (cmd.code)
          capture_pkg::CMD_GATE_START: begin
            acq_reg <= capture_pkg::ACQ_LEVEL;
            runout_reg <= 1'b0;
          end
          capture_pkg::CMD_EDGE_START: begin
            acq_reg <= capture_pkg::ACQ_EDGE_WAIT;
            runout_reg <= 1'b0;
          end
          capture_pkg::CMD_STOP: acq_reg <= capture_pkg::ACQ_IDLE;
          capture_pkg::CMD_CLR_ADDR: cur_addr_reg <= '0;
          capture_pkg::CMD_CLR_ALL: begin
            cur_addr_reg <= '0;
            acq_reg <= capture_pkg::ACQ_IDLE;
          end
          capture_pkg::CMD_SET_ADDR: begin
            if (cmd.arg <= 32'(`ADDR_SET_MAX)) begin
              cur_addr_reg <= cmd.arg[`ADDR_W-1:0];
            end
          end
          default: ;
        endcase
      end else if (acq_reg == capture_pkg::ACQ_EDGE_WAIT && gate_fall) begin
        acq_reg <= capture_pkg::ACQ_EDGE_RUN;
      end else if (store) begin
        cur_addr_reg <= cur_addr_reg + 1'b1;
        if (cur_addr_reg == end_addr_reg || cur_addr_reg == `ADDR_LAST) begin
          acq_reg <= capture_pkg::ACQ_IDLE;
          runout_reg <= 1'b1;
        end
      end
    end
  end

  // pending snapshot waits for fifo space; last values for increments
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pend_reg <= 1'b0;
      pend_rec_reg <= '0;
      last_reg <= '0;
    end else if (ce) begin
      if (pend_reg && fifo_in_ready) begin
        pend_reg <= 1'b0;
      end
      if (store && !pend_reg) begin
        pend_reg <= 1'b1;
        pend_rec_reg <= {cur_addr_reg, snap_val, tmr_reg};
        last_reg <= cnt_reg;
      end
    end
  end

  snap_fifo #(.W($bits(capture_pkg::record_s)), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .in_valid(pend_reg),
    .in_ready(fifo_in_ready),
    .in_data(pend_rec_reg),
    .out_valid(fifo_out_valid),
    .out_ready(!clearing_reg),
    .out_data(fifo_out)
  );

  // record memory: fifo drain, clear walk and read port
  always_ff @(posedge clock) begin
    if (ce) begin
      if (clearing_reg) begin
        mem[clr_ptr_reg] <= '0;
      end else if (fifo_out_valid) begin
        mem[fifo_out.addr] <= fifo_out.data;
      end
      rd_data <= mem[rd_addr];
    end
  end

  // clear-all walk holds off commands until memory is zeroed
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      clearing_reg <= 1'b0;
      clr_ptr_reg <= '0;
      cmd_ready <= 1'b0;
    end else if (ce) begin
      cmd_ready <= !clearing_reg && !(take &&
        cmd.code == capture_pkg::CMD_CLR_ALL);
      if (take && cmd.code == capture_pkg::CMD_CLR_ALL) begin
        clearing_reg <= 1'b1;
        clr_ptr_reg <= '0;
      end else if (clearing_reg) begin
        clr_ptr_reg <= clr_ptr_reg + 1'b1;
        if (clr_ptr_reg == `ADDR_LAST) begin
          clearing_reg <= 1'b0;
        end
      end
    end
  end

  // settings: ack-all mode, capture type, end address
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ack_all_reg <= 1'b0;
      dif_reg <= 1'b0;
      end_addr_reg <= `END_ADDR_RESET;
    end else if (ce && take) begin
      case (cmd.code)
        capture_pkg::CMD_ACK_EN: ack_all_reg <= 1'b1;
        capture_pkg::CMD_ACK_DS: ack_all_reg <= 1'b0;
        capture_pkg::CMD_SEL_DIF: dif_reg <= 1'b1;
        capture_pkg::CMD_SEL_FUL: dif_reg <= 1'b0;
        capture_pkg::CMD_SET_END: begin
          if (cmd.arg <= 32'(`ADDR_LAST)) begin
            end_addr_reg <= cmd.arg[`ADDR_W-1:0];
          end
        end
        default: ;
      endcase
    end
  end

  // internal flag bytes
  assign flag_byte[0] = {4'h0, ovf_reg[3:0]};
  assign flag_byte[1] = {5'h00, ovf_reg[6:4]};
  assign flag_byte[2] = {1'b0, runout_reg, count_en, tmr_ovf_reg,
    ovf_reg[7], pin_level[`CH_COUNT], pin_level[`CH_COUNT+2],
    pin_level[`CH_COUNT+1]};
  assign flag_byte[3] = {5'h00, acq_reg[1], 1'b0,
    acq_reg == capture_pkg::ACQ_LEVEL};

  // replies, one cycle after the command is taken
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      reply <= '0;
      reply_valid <= 1'b0;
    end else if (ce) begin
      reply_valid <= 1'b0;
      reply.tm <= 1'b0;
      reply.data <= '0;
      if (take) begin
        case (cmd.code)
          capture_pkg::CMD_OVF_Q, capture_pkg::CMD_OVFX_Q: begin
            reply_valid <= 1'b1;
            reply.kind <= capture_pkg::REP_OVER;
            reply.data <= {24'h00_0000, ovf_reg};
            reply.tm <= tmr_ovf_reg;
          end
          capture_pkg::CMD_ACK_EN: begin
            reply_valid <= 1'b1;
            reply.kind <= capture_pkg::REP_OK;
          end
          capture_pkg::CMD_ACK_Q: begin
            reply_valid <= 1'b1;
            reply.kind <= ack_all_reg ? capture_pkg::REP_EN
              : capture_pkg::REP_DS;
          end
          capture_pkg::CMD_FLAG_Q: begin
            reply_valid <= 1'b1;
            reply.kind <= capture_pkg::REP_HEX8;
            reply.data <= {24'h00_0000, flag_byte[cmd.arg[1:0]]};
          end
          capture_pkg::CMD_ADDR_Q: begin
            reply_valid <= 1'b1;
            reply.kind <= capture_pkg::REP_DEC;
            reply.data <= 32'(cur_addr_reg);
          end
          capture_pkg::CMD_END_Q: begin
            reply_valid <= 1'b1;
            reply.kind <= capture_pkg::REP_DEC;
            reply.data <= 32'(end_addr_reg);
          end
          capture_pkg::CMD_CAPT_Q: begin
            reply_valid <= 1'b1;
            reply.kind <= dif_reg ? capture_pkg::REP_DIF
              : capture_pkg::REP_FUL;
          end
          capture_pkg::CMD_BAD: begin
            reply_valid <= ack_all_reg;
            reply.kind <= capture_pkg::REP_NG;
          end
          capture_pkg::CMD_ACK_DS: ;
          default: begin
            reply_valid <= ack_all_reg;
            reply.kind <= capture_pkg::REP_OK;
          end
        endcase
      end
    end
  end

  property p_ack_en_ok;
    @(posedge clock) disable iff (!rst_n || !ce)
    take && cmd.code == capture_pkg::CMD_ACK_EN |=>
      reply_valid && reply.kind == capture_pkg::REP_OK && ack_all_reg;
  endproperty
  a_ack_en_ok: assert property (p_ack_en_ok)
    else $error("ack-all enable did not answer OK");

  property p_ack_query;
    @(posedge clock) disable iff (!rst_n || !ce)
    take && cmd.code == capture_pkg::CMD_ACK_Q |=> reply_valid &&
      reply.kind == ($past(ack_all_reg) ? capture_pkg::REP_EN
      : capture_pkg::REP_DS);
  endproperty
  a_ack_query: assert property (p_ack_query)
    else $error("ack-all query answer wrong");

  property p_silent;
    @(posedge clock) disable iff (!rst_n || !ce)
    take && !ack_all_reg && cmd.code == capture_pkg::CMD_SEL_DIF
      |=> !reply_valid;
  endproperty
  a_silent: assert property (p_silent)
    else $error("silent command answered with ack-all off");

  property p_bad_ng;
    @(posedge clock) disable iff (!rst_n || !ce)
    take && ack_all_reg && cmd.code == capture_pkg::CMD_BAD
      |=> reply_valid && reply.kind == capture_pkg::REP_NG;
  endproperty
  a_bad_ng: assert property (p_bad_ng)
    else $error("bad command did not answer NG");

  property p_over;
    @(posedge clock) disable iff (!rst_n || !ce)
    take && cmd.code == capture_pkg::CMD_OVF_Q |=> reply_valid &&
      reply.tm == $past(tmr_ovf_reg) &&
      reply.data[`CH_COUNT-1:0] == $past(ovf_reg);
  endproperty
  a_over: assert property (p_over)
    else $error("overflow answer does not match flags");

  property p_clr_addr;
    @(posedge clock) disable iff (!rst_n || !ce)
    take && cmd.code == capture_pkg::CMD_CLR_ADDR |=> cur_addr_reg == '0;
  endproperty
  a_clr_addr: assert property (p_clr_addr)
    else $error("clear-address left address nonzero");

  property p_store_step;
    @(posedge clock) disable iff (!rst_n || !ce)
    store |=> cur_addr_reg == $past(cur_addr_reg) + 1'b1;
  endproperty
  a_store_step: assert property (p_store_step)
    else $error("store did not advance address by one");

  property p_end_stop;
    @(posedge clock) disable iff (!rst_n || !ce)
    store && cur_addr_reg == end_addr_reg
      |=> acq_reg == capture_pkg::ACQ_IDLE && runout_reg;
  endproperty
  a_end_stop: assert property (p_end_stop)
    else $error("acquisition ran past end address");

  property p_level_gate;
    @(posedge clock) disable iff (!rst_n || !ce)
    acq_reg == capture_pkg::ACQ_LEVEL && !pin_level[`CH_COUNT]
      |=> $stable(cnt_reg);
  endproperty
  a_level_gate: assert property (p_level_gate)
    else $error("counted with gate low in gate-level mode");

  property p_clear_busy;
    @(posedge clock) disable iff (!rst_n || !ce)
    take && cmd.code == capture_pkg::CMD_CLR_ALL
      |=> !cmd_ready && clearing_reg ##1 !cmd_ready [*8];
  endproperty
  a_clear_busy: assert property (p_clear_busy)
    else $error("commands accepted during clear-all");

  c_level_store: cover property (@(posedge clock) disable iff (!rst_n)
    acq_reg == capture_pkg::ACQ_LEVEL && store);
  c_edge_store: cover property (@(posedge clock) disable iff (!rst_n)
    acq_reg == capture_pkg::ACQ_EDGE_RUN && store);
  c_runout: cover property (@(posedge clock) disable iff (!rst_n)
    $rose(runout_reg));
endmodule

// ---- testbench/cmd_host.sv ----
// host model: issues decoded commands on the command port
// assumes the bench clock; the request changes only on falling edges
`timescale 1ns/1ns
module cmd_host (
  input wire logic clock,
  input wire logic cmd_ready,
  output capture_pkg::cmd_s cmd,
  output logic cmd_valid
);
  // idle bus at time zero
  initial begin
    cmd = '0;
    cmd_valid = 1'b0;
  end

  // hold the request until an edge sees ready or 40000 edges pass, then release
  task automatic issue(input capture_pkg::cmd_e c, input logic [31:0] a);
    int n;
    @(negedge clock);
    cmd.code = c;
    cmd.arg = a;
    cmd_valid = 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (cmd_ready !== 1'b1 && n < 40000);
    @(negedge clock);
    cmd_valid = 1'b0;
    cmd.arg = ~a; // released bus shows no stale argument
  endtask
endmodule

// ---- testbench/gated_count_capture_to_memory_tb.sv ----
// self-checking bench for the gated count capture block
// assumes capture_pkg is compiled first and cmd_host plays the host
`timescale 1ns/1ns
`include "capture_cfg.svh"
module gated_count_capture_to_memory_tb;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic gate_pin = 1'b0;
  logic start_pin = 1'b0;
  logic stop_pin = 1'b0;
  logic ce = 1'b1;
  logic [`CH_COUNT-1:0] count_pin = '0;
  logic [`ADDR_W-1:0] rd_addr = '0;
  logic cmd_valid, cmd_ready, reply_valid;
  capture_pkg::cmd_s cmd;
  capture_pkg::reply_s reply, e_r;
  capture_pkg::rec_data_s rd_data;
  capture_pkg::reply_s exp_q[$];
  int err_total = 0;
  int checks = 0;
  int seed = 37;
  int n1[8], n2[8], n3[8];
  int z[8] = '{default: 0};
  logic [31:0] a;

  // 100 MHz clock
  always #5 clock = ~clock;

  gated_count_capture_to_memory i_dut (.clock(clock), .rst_n(rst_n),
    .ce(ce), .cmd(cmd), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .reply(reply), .reply_valid(reply_valid), .count_pin(count_pin),
    .gate_pin(gate_pin), .start_pin(start_pin), .stop_pin(stop_pin),
    .rd_addr(rd_addr), .rd_data(rd_data));

  cmd_host i_host (.clock(clock), .cmd_ready(cmd_ready), .cmd(cmd),
    .cmd_valid(cmd_valid));

  // one comparison, counted and reported on mismatch
  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] s);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", what, e, s);
    end
  endtask

  // note the expected answer, then send the command
  task automatic ask(input capture_pkg::cmd_e c, input logic [31:0] x,
                     input capture_pkg::reply_e k, input logic [31:0] d);
    exp_q.push_back(capture_pkg::reply_s'{kind: k, tm: 1'b0, data: d});
    i_host.issue(c, x);
  endtask

  // reply watcher: any reply takes the oldest note, none may be extra
  always @(negedge clock) begin
    if (reply_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("reply count", '0, 32'h0000_0001);
      end else begin
        e_r = exp_q.pop_front();
        chk("reply kind", 32'(e_r.kind), 32'(reply.kind));
        if (e_r.kind == capture_pkg::REP_OVER)
          chk("reply tm", 32'(e_r.tm), 32'(reply.tm));
        if (e_r.kind inside {capture_pkg::REP_OVER, capture_pkg::REP_HEX8,
                             capture_pkg::REP_DEC})
          chk("reply data", e_r.data, reply.data);
      end
    end
  end

  // one gate period with random pulse counts per channel; the period
  // stays well above the store time of the capture path
  task automatic gate_period(output int n[8]);
    @(negedge clock);
    gate_pin = 1'b1;
    for (int c = 0; c < 8; c++) n[c] = 1 + {$random(seed)} % 6;
    repeat (10) @(negedge clock);
    for (int k = 0; k < 6; k++) begin
      for (int c = 0; c < 8; c++) count_pin[c] = (n[c] > k);
      repeat (6) @(negedge clock);
      count_pin = '0;
      repeat (6) @(negedge clock);
    end
    gate_pin = 1'b0;
    repeat (60) @(negedge clock);
  endtask

  // read one stored record and compare every channel
  task automatic rec_chk(input logic [`ADDR_W-1:0] ad, input int n[8]);
    @(negedge clock);
    rd_addr = ad;
    repeat (2) @(negedge clock);
    for (int c = 0; c < 8; c++)
      chk("record count", 32'(n[c]), rd_data.cnt[c]);
  endtask

  // verdict and end of run
  task automatic tally_and_finish();
    if (err_total == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // watchdog
  initial begin
    #600000;
    err_total++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    repeat (8) @(negedge clock);
    rst_n = 1'b1;
    ask(capture_pkg::CMD_ACK_Q, '0, capture_pkg::REP_DS, '0);
    ask(capture_pkg::CMD_CAPT_Q, '0, capture_pkg::REP_FUL, '0);
    ask(capture_pkg::CMD_END_Q, '0, capture_pkg::REP_DEC, 29999);
    ask(capture_pkg::CMD_ACK_EN, '0, capture_pkg::REP_OK, '0);
    ask(capture_pkg::CMD_ACK_Q, '0, capture_pkg::REP_EN, '0);
    ask(capture_pkg::CMD_BAD, '0, capture_pkg::REP_NG, '0);
    ask(capture_pkg::CMD_SEL_FUL, '0, capture_pkg::REP_OK, '0);
    i_host.issue(capture_pkg::CMD_ACK_DS, '0);
    i_host.issue(capture_pkg::CMD_CLR_ADDR, '0);
    ask(capture_pkg::CMD_ACK_Q, '0, capture_pkg::REP_DS, '0);
    a = {$random(seed)} % 10000;
    i_host.issue(capture_pkg::CMD_SET_ADDR, a);
    ask(capture_pkg::CMD_ADDR_Q, '0, capture_pkg::REP_DEC, a);
    i_host.issue(capture_pkg::CMD_SET_ADDR, 10000);
    ask(capture_pkg::CMD_ADDR_Q, '0, capture_pkg::REP_DEC, a);
    i_host.issue(capture_pkg::CMD_SET_ADDR, 5);
    i_host.issue(capture_pkg::CMD_SET_END, 7);
    ask(capture_pkg::CMD_END_Q, '0, capture_pkg::REP_DEC, 7);
    i_host.issue(capture_pkg::CMD_GATE_START, '0);
    ask(capture_pkg::CMD_FLAG_Q, 3, capture_pkg::REP_HEX8, 1);
    gate_period(n1);
    i_host.issue(capture_pkg::CMD_SEL_DIF, '0);
    ask(capture_pkg::CMD_CAPT_Q, '0, capture_pkg::REP_DIF, '0);
    gate_period(n2);
    start_pin = 1'b1;
    gate_period(n3);
    ask(capture_pkg::CMD_ADDR_Q, '0, capture_pkg::REP_DEC, 8);
    ask(capture_pkg::CMD_FLAG_Q, 2, capture_pkg::REP_HEX8, 'h41);
    ask(capture_pkg::CMD_FLAG_Q, 0, capture_pkg::REP_HEX8, '0);
    ask(capture_pkg::CMD_FLAG_Q, 1, capture_pkg::REP_HEX8, '0);
    ask(capture_pkg::CMD_OVF_Q, '0, capture_pkg::REP_OVER, '0);
    ask(capture_pkg::CMD_OVFX_Q, '0, capture_pkg::REP_OVER, '0);
    rec_chk(5, n1);
    rec_chk(6, n2);
    rec_chk(7, n3);
    i_host.issue(capture_pkg::CMD_CLR_ADDR, '0);
    ask(capture_pkg::CMD_ADDR_Q, '0, capture_pkg::REP_DEC, '0);
    rec_chk(5, n1);
    i_host.issue(capture_pkg::CMD_SET_ADDR, 10);
    i_host.issue(capture_pkg::CMD_SET_END, 11);
    i_host.issue(capture_pkg::CMD_EDGE_START, '0);
    ask(capture_pkg::CMD_FLAG_Q, 3, capture_pkg::REP_HEX8, 4);
    gate_period(n1);
    ask(capture_pkg::CMD_ADDR_Q, '0, capture_pkg::REP_DEC, 10);
    gate_period(n2);
    gate_period(n3);
    ask(capture_pkg::CMD_ADDR_Q, '0, capture_pkg::REP_DEC, 12);
    rec_chk(10, n2);
    rec_chk(11, n3);
    i_host.issue(capture_pkg::CMD_SET_ADDR, 15);
    i_host.issue(capture_pkg::CMD_SET_END, 20);
    i_host.issue(capture_pkg::CMD_GATE_START, '0);
    gate_period(n1);
    // clock enable low freezes pins and state: no store in this period
    ce = 1'b0;
    gate_period(n2);
    ce = 1'b1;
    ask(capture_pkg::CMD_ADDR_Q, '0, capture_pkg::REP_DEC, 16);
    i_host.issue(capture_pkg::CMD_STOP, '0);
    gate_period(n2);
    ask(capture_pkg::CMD_ADDR_Q, '0, capture_pkg::REP_DEC, 16);
    i_host.issue(capture_pkg::CMD_CLR_ALL, '0);
    chk("ready while clearing", '0, 32'(cmd_ready));
    ask(capture_pkg::CMD_ADDR_Q, '0, capture_pkg::REP_DEC, '0);
    rec_chk(5, z);
    repeat (4) @(negedge clock);
    chk("replies outstanding", '0, 32'(exp_q.size()));
    tally_and_finish();
  end
endmodule
